// file: design/uia_pkg.sv
package uia_pkg;
    typedef logic [7:0] uia_byte_type;
    typedef logic [5:0] uia_code_type;
    // source order, index 0 is the highest priority
    typedef enum logic [2:0] {
        UIA_SRC_LINE = 3'b000,
        UIA_SRC_TIMEOUT = 3'b001,
        UIA_SRC_RXDATA = 3'b010,
        UIA_SRC_TXHOLD = 3'b011,
        UIA_SRC_MODEM = 3'b100,
        UIA_SRC_XOFF = 3'b101,
        UIA_SRC_FLOW = 3'b110
    } uia_src_type;
    localparam int UIA_NUM_SRC = 7;
endpackage : uia_pkg

// file: design/uia_prio.sv
`timescale 1ns/1ps
`include "uia_regs.svh"

module uia_prio
    import uia_pkg::*;
(
    // enabled pending sources, indexed by uia_src_type
    input wire logic [UIA_NUM_SRC-1:0] active,
    // winning code, bits 5:0
    output uia_code_type code
);
    always_comb begin
        code = `UIA_CODE_NONE;
        if (active[UIA_SRC_LINE]) begin
            code = `UIA_CODE_LINE;
        end else if (active[UIA_SRC_TIMEOUT]) begin
            code = `UIA_CODE_TIMEOUT;
        end else if (active[UIA_SRC_RXDATA]) begin
            code = `UIA_CODE_RXDATA;
        end else if (active[UIA_SRC_TXHOLD]) begin
            code = `UIA_CODE_TXHOLD;
        end else if (active[UIA_SRC_MODEM]) begin
            code = `UIA_CODE_MODEM;
        end else if (active[UIA_SRC_XOFF]) begin
            code = `UIA_CODE_XOFF;
        end else if (active[UIA_SRC_FLOW]) begin
            code = `UIA_CODE_FLOW;
        end
    end
endmodule : uia_prio

// file: design/uia_regs.svh
`ifndef UIA_REGS_SVH
`define UIA_REGS_SVH

// register offsets on the host bus
`define UIA_ADDR_ENABLES 3'h1
`define UIA_ADDR_IDENTIFY 3'h2
`define UIA_ADDR_ENHANCED 3'h3

// interrupt_source_enables fields
`define UIA_IE_RXDATA 0
`define UIA_IE_TXHOLD 1
`define UIA_IE_LINE 2
`define UIA_IE_MODEM 3
`define UIA_IE_SLEEP 4
`define UIA_IE_XOFF 5
`define UIA_IE_RTS 6
`define UIA_IE_CTS 7
`define UIA_IE_LOW_MASK 8'h0f

// enhanced_feature_control fields
`define UIA_EF_WRITE_EN 4
`define UIA_EF_AUTO_RTS 6
`define UIA_EF_AUTO_CTS 7

// reset values
`define UIA_ENABLES_RESET 8'h00
`define UIA_ENHANCED_RESET 8'h00
`define UIA_IDENTIFY_RESET 6'h01

// identify codes, bits 5:0
`define UIA_CODE_NONE 6'h01
`define UIA_CODE_LINE 6'h06
`define UIA_CODE_TIMEOUT 6'h0c
`define UIA_CODE_RXDATA 6'h04
`define UIA_CODE_TXHOLD 6'h02
`define UIA_CODE_MODEM 6'h00
`define UIA_CODE_XOFF 6'h10
`define UIA_CODE_FLOW 6'h20

`endif

// file: design/uia_top.sv
// How it works
// - enable bits 0..3 gate rx data, tx holding, line status, modem; reset off.
// - enable bits 5,6,7 gate xoff, rts change, cts change; reset off.
// - enable bit 4 set puts the channel in sleep; clear leaves it.
// - enable bits 7:4 only writable while enhanced write enable is set.
// - re-enabling tx holding interrupt never makes a new one by itself.
// - interrupt output active whenever any enabled source is pending.
// - identify bit 0 is 0 while pending, 1 when nothing pending.
// - identify bits 7:6 copy the fifo enable bit.
// - line status 000110 first; timeout 001100 then rx data 000100.
// - only the top source reported; tx holding 000010, modem 000000.
// - xoff or special character reported as 010000, sixth of the seven in priority order.
// - cts or rts low-to-high change reported as 100000, lowest priority.
// - auto cts on enhanced bit 7 stops transmit while clear-to-send high.
// - auto rts on bit 6: high at halt level, low at resume level.
// - enhanced bit 4 is write enable for the guarded upper bits.
// - thresholds are levels 0 to 60 bytes in steps of four.
// - interrupt output undriven while modem control bit 3 is 0.
`timescale 1ns/1ps
`include "uia_regs.svh"

module uia_top
    import uia_pkg::*;
#(
    parameter int LEVEL_W = 7
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // host register bus
    input wire logic [2:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_write,
    input wire logic cpu_read,
    output uia_byte_type cpu_rdata,
    // from other uart registers
    input wire logic fifo_enable,
    input wire logic irq_drive_enable,
    input wire logic modem_rts,
    input wire logic [7:0] flow_threshold_reg,
    // interrupt sources
    input wire logic line_status_err,
    input wire logic rx_timeout,
    input wire logic rx_data_ready,
    input wire logic tx_below_level,
    input wire logic tx_holding_write,
    input wire logic modem_status_change,
    input wire logic xoff_detected,
    // flow control
    input wire logic clear_to_send_in,
    input wire logic [LEVEL_W-1:0] rx_fifo_level,
    output logic request_to_send_out,
    output logic tx_stop,
    // channel status
    output logic sleep_mode,
    output logic irq_out_a,
    output logic irq_out_a_oe
);

    ////////////////////////////////////////////////////////////////////////
    // registers and host bus
    uia_byte_type interrupt_source_enables;
    uia_byte_type enhanced_feature_control;
    uia_byte_type interrupt_source_identify;
    uia_code_type next_code;
    logic [UIA_NUM_SRC-1:0] active;
    logic wr_enables;
    logic wr_enhanced;
    logic rd_identify;

    assign wr_enables = cpu_write && cpu_addr == `UIA_ADDR_ENABLES;
    assign wr_enhanced = cpu_write && cpu_addr == `UIA_ADDR_ENHANCED;
    assign rd_identify = cpu_read && cpu_addr == `UIA_ADDR_IDENTIFY;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            interrupt_source_enables <= `UIA_ENABLES_RESET;
        end else if (wr_enables) begin
            if (enhanced_feature_control[`UIA_EF_WRITE_EN]) begin
                interrupt_source_enables <= cpu_wdata;
            end else begin
                interrupt_source_enables <= (interrupt_source_enables & ~`UIA_IE_LOW_MASK)
                    | (cpu_wdata & `UIA_IE_LOW_MASK);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            enhanced_feature_control <= `UIA_ENHANCED_RESET;
        end else if (wr_enhanced) begin
            enhanced_feature_control <= cpu_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_read) begin
            case (cpu_addr)
                `UIA_ADDR_ENABLES: cpu_rdata <= interrupt_source_enables;
                `UIA_ADDR_IDENTIFY: cpu_rdata <= interrupt_source_identify;
                `UIA_ADDR_ENHANCED: cpu_rdata <= enhanced_feature_control;
                default: cpu_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky sources
    logic tx_below_q;
    logic cts_q;
    logic rts_q;
    logic txhold_pend;
    logic xoff_pend;
    logic cts_pend;
    logic rts_pend;
    logic rd_txhold;
    logic rd_xoff;
    logic rd_flow;

    assign rd_txhold = rd_identify && interrupt_source_identify[5:0] == `UIA_CODE_TXHOLD;
    assign rd_xoff = rd_identify && interrupt_source_identify[5:0] == `UIA_CODE_XOFF;
    assign rd_flow = rd_identify && interrupt_source_identify[5:0] == `UIA_CODE_FLOW;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tx_below_q <= 1'b0;
            // idle high, so no false rising edge after reset
            cts_q <= 1'b1;
            rts_q <= 1'b1;
        end else begin
            tx_below_q <= tx_below_level;
            cts_q <= clear_to_send_in;
            rts_q <= request_to_send_out;
        end
    end

    // tx holding set only by the level crossing, not by the enable
    always_ff @(posedge clock) begin
        if (!resetn) begin
            txhold_pend <= 1'b0;
        end else begin
            txhold_pend <= (txhold_pend & ~(rd_txhold | tx_holding_write))
                | (tx_below_level & ~tx_below_q);
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            xoff_pend <= 1'b0;
        end else begin
            xoff_pend <= (xoff_pend & ~rd_xoff) | xoff_detected;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            cts_pend <= 1'b0;
            rts_pend <= 1'b0;
        end else begin
            cts_pend <= (cts_pend & ~rd_flow) | (clear_to_send_in & ~cts_q);
            rts_pend <= (rts_pend & ~rd_flow) | (request_to_send_out & ~rts_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // priority and identify
    always_comb begin
        active = '0;
        active[UIA_SRC_LINE] = line_status_err & interrupt_source_enables[`UIA_IE_LINE];
        active[UIA_SRC_TIMEOUT] = rx_timeout & interrupt_source_enables[`UIA_IE_RXDATA];
        active[UIA_SRC_RXDATA] = rx_data_ready & interrupt_source_enables[`UIA_IE_RXDATA];
        active[UIA_SRC_TXHOLD] = txhold_pend & interrupt_source_enables[`UIA_IE_TXHOLD];
        active[UIA_SRC_MODEM] = modem_status_change & interrupt_source_enables[`UIA_IE_MODEM];
        active[UIA_SRC_XOFF] = xoff_pend & interrupt_source_enables[`UIA_IE_XOFF];
        active[UIA_SRC_FLOW] = (cts_pend & interrupt_source_enables[`UIA_IE_CTS])
            | (rts_pend & interrupt_source_enables[`UIA_IE_RTS]);
    end

    uia_prio uia_prio_i (
        .active(active),
        .code(next_code)
    );

    always_ff @(posedge clock) begin
        if (!resetn) begin
            interrupt_source_identify <= {2'b00, `UIA_IDENTIFY_RESET};
        end else begin
            interrupt_source_identify <= {{2{fifo_enable}}, next_code};
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_out_a <= 1'b0;
            irq_out_a_oe <= 1'b0;
            sleep_mode <= 1'b0;
        end else begin
            irq_out_a <= |active;
            irq_out_a_oe <= irq_drive_enable;
            sleep_mode <= interrupt_source_enables[`UIA_IE_SLEEP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // hardware flow control
    function automatic logic [LEVEL_W-1:0] level_bytes(input logic [3:0] nib);
        level_bytes = LEVEL_W'({nib, 2'b00});
    endfunction : level_bytes

    always_ff @(posedge clock) begin
        if (!resetn) begin
            tx_stop <= 1'b0;
        end else begin
            tx_stop <= enhanced_feature_control[`UIA_EF_AUTO_CTS] & clear_to_send_in;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            request_to_send_out <= 1'b1;
        end else if (!enhanced_feature_control[`UIA_EF_AUTO_RTS]) begin
            request_to_send_out <= ~modem_rts;
        end else if (rx_fifo_level >= level_bytes(flow_threshold_reg[3:0])) begin
            request_to_send_out <= 1'b1;
        end else if (rx_fifo_level <= level_bytes(flow_threshold_reg[7:4])) begin
            request_to_send_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_UPPER_LOCKED: assert property (@(posedge clock) disable iff (!resetn)
        wr_enables && !enhanced_feature_control[`UIA_EF_WRITE_EN]
        |=> interrupt_source_enables[7:4] == $past(interrupt_source_enables[7:4]))
        else $error("upper enables changed while locked");
    AST_LOW_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        wr_enables |=> interrupt_source_enables[3:0] == $past(cpu_wdata[3:0]))
        else $error("lower enables not written");
    AST_NO_REARM: assert property (@(posedge clock) disable iff (!resetn)
        !txhold_pend && !(tx_below_level && !tx_below_q) |=> !txhold_pend)
        else $error("tx holding pending without a crossing");
    AST_IRQ_FOLLOWS: assert property (@(posedge clock) disable iff (!resetn)
        |active |=> irq_out_a)
        else $error("interrupt output not raised");
    AST_PEND_BIT: assert property (@(posedge clock) disable iff (!resetn)
        ##1 interrupt_source_identify[0] == !$past(|active))
        else $error("identify bit 0 wrong");
    AST_MIRROR: assert property (@(posedge clock) disable iff (!resetn)
        fifo_enable |=> interrupt_source_identify[7:6] == 2'b11)
        else $error("fifo enable mirror wrong");
    AST_LINE_FIRST: assert property (@(posedge clock) disable iff (!resetn)
        active[UIA_SRC_LINE] |=> interrupt_source_identify[5:0] == `UIA_CODE_LINE)
        else $error("line status not first");
    AST_XOFF_CODE: assert property (@(posedge clock) disable iff (!resetn)
        active[UIA_SRC_XOFF] && !(|active[UIA_SRC_MODEM:UIA_SRC_LINE])
        |=> interrupt_source_identify[5:0] == `UIA_CODE_XOFF)
        else $error("xoff code wrong");
    AST_FLOW_CODE: assert property (@(posedge clock) disable iff (!resetn)
        active[UIA_SRC_FLOW] && !(|active[UIA_SRC_XOFF:UIA_SRC_LINE])
        |=> interrupt_source_identify[5:0] == `UIA_CODE_FLOW)
        else $error("flow change code wrong");
    AST_CTS_STOP: assert property (@(posedge clock) disable iff (!resetn)
        enhanced_feature_control[`UIA_EF_AUTO_CTS] && clear_to_send_in |=> tx_stop)
        else $error("transmit not stopped");
    AST_RTS_HALT: assert property (@(posedge clock) disable iff (!resetn)
        enhanced_feature_control[`UIA_EF_AUTO_RTS]
        && rx_fifo_level >= level_bytes(flow_threshold_reg[3:0]) |=> request_to_send_out)
        else $error("rts not raised at halt level");
    AST_OE: assert property (@(posedge clock) disable iff (!resetn)
        !irq_drive_enable |=> !irq_out_a_oe)
        else $error("interrupt driven while disabled");

endmodule : uia_top

// file: tb/uart_interrupt_and_auto_flow_test.sv
`timescale 1ns/1ps
`include "uia_regs.svh"

module uart_interrupt_and_auto_flow_test;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic fe = 1'b0, ide = 1'b0, mrts = 1'b0, line = 1'b0, tmo = 1'b0, rxd = 1'b0;
    logic txb = 1'b0, txw = 1'b0, msc = 1'b0, xoff = 1'b0, cts = 1'b0;
    logic [7:0] tx_holding = 8'h00;
    logic [6:0] lvl = 7'h00;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, v;
    logic wr, rd, rts, txs, slp, irq, oe;
    logic [5:0] codes [7];
    logic [6:0] lv [4] = '{7'h06, 7'h08, 7'h06, 7'h04};
    logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    int fail_count = 0, n_checks = 0, cyc = 0;

    always #4 clock = ~clock;

    uia_host uia_host_i (.clock(clock), .cpu_addr(addr), .cpu_wdata(wdata), .cpu_write(wr),
        .cpu_read(rd), .cpu_rdata(rdata));
    uia_top uia_top_i (.clock(clock), .resetn(resetn), .cpu_addr(addr), .cpu_wdata(wdata),
        .cpu_write(wr), .cpu_read(rd), .cpu_rdata(rdata), .fifo_enable(fe), .irq_drive_enable(ide),
        .modem_rts(mrts), .flow_threshold_reg(tx_holding), .line_status_err(line), .rx_timeout(tmo),
        .rx_data_ready(rxd), .tx_below_level(txb), .tx_holding_write(txw), .modem_status_change(msc),
        .xoff_detected(xoff), .clear_to_send_in(cts), .rx_fifo_level(lvl), .request_to_send_out(rts),
        .tx_stop(txs), .sleep_mode(slp), .irq_out_a(irq), .irq_out_a_oe(oe));

    ////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : check8

    task automatic check1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask : check1

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string nm);
        uia_host_i.rd(a, v);
        check8(nm, e, v);
    endtask : rdchk

    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        codes = '{`UIA_CODE_LINE, `UIA_CODE_TIMEOUT, `UIA_CODE_RXDATA, `UIA_CODE_TXHOLD,
            `UIA_CODE_MODEM, `UIA_CODE_XOFF, `UIA_CODE_FLOW};
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        tick(1);
        check1("rts", 1'b1, rts);
        check1("irq", 1'b0, irq);
        check1("oe", 1'b0, oe);
        check1("sleep", 1'b0, slp);
        rdchk(`UIA_ADDR_ENABLES, 8'h00, "enables");
        rdchk(`UIA_ADDR_IDENTIFY, 8'h01, "identify");
        rdchk(`UIA_ADDR_ENHANCED, 8'h00, "enhanced");
        rdchk(3'h7, 8'h00, "unmapped");
        // upper enables guarded by write enable
        uia_host_i.wr(`UIA_ADDR_ENABLES, 8'hff);
        rdchk(`UIA_ADDR_ENABLES, 8'h0f, "enables");
        uia_host_i.wr(`UIA_ADDR_ENHANCED, 8'h10);
        uia_host_i.wr(`UIA_ADDR_ENABLES, 8'hff);
        rdchk(`UIA_ADDR_ENABLES, 8'hff, "enables");
        check1("sleep", 1'b1, slp);
        // all sources pending, drained in priority order
        @(posedge clock);
        fe <= 1'b1;
        ide <= 1'b1;
        {line, tmo, rxd, txb, msc, xoff, cts} <= 7'h7f;
        @(posedge clock);
        xoff <= 1'b0;
        tick(3);
        check1("irq", 1'b1, irq);
        check1("oe", 1'b1, oe);
        for (int i = 0; i < 7; i++) begin
            rdchk(`UIA_ADDR_IDENTIFY, {2'b11, codes[i]}, "identify");
            check1("xoff_seen", i == 5, uia_host_i.xoff_seen);
            @(posedge clock);
            line <= line && i != 0;
            tmo <= tmo && i != 1;
            rxd <= rxd && i != 2;
            msc <= msc && i != 4;
            tick(2);
        end
        check1("irq", 1'b0, irq);
        rdchk(`UIA_ADDR_IDENTIFY, 8'hc1, "identify");
        // tx holding cleared by a holding write, not revived by re-enabling
        @(posedge clock);
        txb <= 1'b0;
        @(posedge clock);
        txb <= 1'b1;
        tick(3);
        check1("irq", 1'b1, irq);
        @(posedge clock);
        txw <= 1'b1;
        @(posedge clock);
        txw <= 1'b0;
        uia_host_i.wr(`UIA_ADDR_ENABLES, 8'hfd);
        uia_host_i.wr(`UIA_ADDR_ENABLES, 8'hff);
        tick(3);
        check1("irq", 1'b0, irq);
        rdchk(`UIA_ADDR_IDENTIFY, 8'hc1, "identify");
        // auto clear-to-send
        uia_host_i.wr(`UIA_ADDR_ENHANCED, 8'h90);
        tick(2);
        check1("tx_stop", 1'b1, txs);
        @(posedge clock);
        cts <= 1'b0;
        tick(2);
        check1("tx_stop", 1'b0, txs);
        // auto request-to-send, halt 8 bytes, resume 4 bytes
        @(posedge clock);
        tx_holding <= 8'h12;
        uia_host_i.wr(`UIA_ADDR_ENHANCED, 8'h50);
        tick(2);
        check1("rts", 1'b0, rts);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            lvl <= lv[i];
            tick(2);
            check1("rts", ex[i], rts);
        end
        // leave sleep, then freeze upper bits
        uia_host_i.wr(`UIA_ADDR_ENABLES, 8'h0f);
        tick(2);
        check1("sleep", 1'b0, slp);
        uia_host_i.wr(`UIA_ADDR_ENHANCED, 8'h00);
        uia_host_i.wr(`UIA_ADDR_ENABLES, 8'hf0);
        rdchk(`UIA_ADDR_ENABLES, 8'h00, "enables");
        @(posedge clock);
        ide <= 1'b0;
        mrts <= 1'b1;
        tick(2);
        check1("oe", 1'b0, oe);
        check1("rts", 1'b0, rts);
        summarize();
    end
endmodule : uart_interrupt_and_auto_flow_test

// file: tb/uia_host.sv
`timescale 1ns/1ps
`include "uia_regs.svh"

module uia_host (
    // clock
    input wire logic clock,
    // register bus
    output logic [2:0] cpu_addr,
    output logic [7:0] cpu_wdata,
    output logic cpu_write,
    output logic cpu_read,
    input wire logic [7:0] cpu_rdata
);
    logic xoff_seen = 1'b0;

    initial begin
        cpu_addr = 3'h0;
        cpu_wdata = 8'h00;
        cpu_write = 1'b0;
        cpu_read = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // single byte write, one strobe cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_write <= 1'b1;
        @(posedge clock);
        cpu_write <= 1'b0;
        cpu_addr <= ~a;
        cpu_wdata <= ~d;
    endtask : wr

    // single byte read, data one cycle later
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        cpu_addr <= a;
        cpu_read <= 1'b1;
        @(posedge clock);
        cpu_read <= 1'b0;
        cpu_addr <= ~a;
        #1;
        d = cpu_rdata;
        if (a == `UIA_ADDR_IDENTIFY) xoff_seen = cpu_rdata[4];
    endtask : rd
endmodule : uia_host
